// *** design/port2_strap_defaults.sv ***
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module port2_strap_defaults (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [strap_defaults_pkg::STRAP_W-1:0] strap_pins,
   input wire logic loader_valid,
   input wire logic [strap_defaults_pkg::STRAP_W-1:0] loader_straps,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic port2_speed_100,
   output logic port2_full_duplex,
   output logic port2_backpressure_enable,
   output logic port2_tx_pause_enable,
   output logic port2_rx_pause_enable,
   output logic port2_manual_flow_control
);
   import strap_defaults_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ***************************************************
   // Strap capture
   // ***************************************************
   logic [STRAP_W-1:0] pins_sync;
   logic [STRAP_W-1:0] strap_reg;
   logic [STRAP_W-1:0] eff_straps;
   logic in_reset_reg;
   logic apply_now;
   // Synchroniser runs through reset so pins are settled at release
   strap_sync #(.WIDTH(STRAP_W)) u_sync (
      .aclk(aclk),
      .async_in(strap_pins),
      .sync_out(pins_sync)
   );
   // Loader values override pins
   // loader overrides pins
   assign eff_straps = loader_valid ? loader_straps : pins_sync;
   // High in reset and in the first cycle after release
   always_ff @(posedge aclk) begin
      in_reset_reg <= !aresetn;
   end
   // Capture taken by clock, never by reset value of a port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_reg <= STRAP_DEFAULT;
      end else if (in_reset_reg) begin
         strap_reg <= eff_straps;
      end
   end
   assign apply_now = in_reset_reg;
   // ***************************************************
   // Register fields
   // ***************************************************
   logic speed_reg;
   logic duplex_reg;
   logic adv_10fd_reg;
   logic adv_10hd_reg;
   logic [MODE_W-1:0] mode_reg;
   logic bp_reg;
   logic txfc_reg;
   logic rxfc_reg;
   logic manual_reg;
   logic wr_fire;
   logic [7:0] aw_reg;
   logic [31:0] w_reg;
   logic [3:0] ws_reg;
   logic aw_have;
   logic w_have;
   logic wr_lane0;
   logic wr_lane1;

   assign wr_fire = aw_have && w_have && !s_axi_bvalid;
   assign wr_lane0 = ws_reg[0];
   assign wr_lane1 = ws_reg[1];

   // Strap-derived defaults, then software ownership
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speed_reg <= STRAP_DEFAULT[STRAP_SPEED_BIT];
         duplex_reg <= STRAP_DEFAULT[STRAP_DUPLEX_BIT];
         adv_10fd_reg <= 1'b1;
         adv_10hd_reg <= 1'b1;
         mode_reg <= MODE_100FD;
         bp_reg <= STRAP_DEFAULT[STRAP_BP_BIT];
         txfc_reg <= STRAP_DEFAULT[STRAP_PAUSE_BIT];
         rxfc_reg <= STRAP_DEFAULT[STRAP_PAUSE_BIT];
         manual_reg <= 1'b0;
      end else if (apply_now) begin
         speed_reg <= eff_straps[STRAP_SPEED_BIT];
         duplex_reg <= eff_straps[STRAP_DUPLEX_BIT];
         adv_10fd_reg <= eff_straps[STRAP_SPEED_BIT] | eff_straps[STRAP_DUPLEX_BIT];
         adv_10hd_reg <= eff_straps[STRAP_SPEED_BIT] | 1'b1;
         case ({eff_straps[STRAP_SPEED_BIT], eff_straps[STRAP_DUPLEX_BIT]})
            2'b00: mode_reg <= MODE_10HD;
            2'b01: mode_reg <= MODE_10FD;
            2'b10: mode_reg <= MODE_100HD;
            default: mode_reg <= MODE_100FD;
         endcase
         bp_reg <= eff_straps[STRAP_BP_BIT];
         txfc_reg <= eff_straps[STRAP_PAUSE_BIT];
         rxfc_reg <= eff_straps[STRAP_PAUSE_BIT];
      end else if (wr_fire) begin
         if (aw_reg == BASIC_CTRL_OFFSET && wr_lane1) begin
            duplex_reg <= w_reg[DUPLEX_BIT];
            speed_reg <= w_reg[SPEED_LSB_BIT];
         end
         if (aw_reg == AN_ADV_OFFSET && wr_lane0) begin
            adv_10fd_reg <= w_reg[ADV_10FD_BIT];
            adv_10hd_reg <= w_reg[ADV_10HD_BIT];
         end
         if (aw_reg == SPECIAL_MODES_OFFSET && wr_lane0) begin
            mode_reg <= w_reg[MODE_LSB +: MODE_W];
         end
         if (aw_reg == MANUAL_FC_OFFSET && wr_lane0) begin
            bp_reg <= w_reg[FC_BP_BIT];
            rxfc_reg <= w_reg[FC_RX_BIT];
            txfc_reg <= w_reg[FC_TX_BIT];
            manual_reg <= w_reg[FC_MANUAL_BIT];
         end
      end
   end

   // Outputs from flops; pause enables only act in manual full duplex
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port2_speed_100 <= 1'b0;
         port2_full_duplex <= 1'b0;
         port2_backpressure_enable <= 1'b0;
         port2_tx_pause_enable <= 1'b0;
         port2_rx_pause_enable <= 1'b0;
         port2_manual_flow_control <= 1'b0;
      end else begin
         port2_speed_100 <= speed_reg;
         port2_full_duplex <= duplex_reg;
         port2_backpressure_enable <= bp_reg;
         port2_tx_pause_enable <= txfc_reg && manual_reg && duplex_reg;
         port2_rx_pause_enable <= rxfc_reg && manual_reg && duplex_reg;
         port2_manual_flow_control <= manual_reg;
      end
   end

   // ***************************************************
   // AXI4-Lite write channel
   // ***************************************************
   logic wr_known;
   assign wr_known = aw_reg == BASIC_CTRL_OFFSET || aw_reg == AN_ADV_OFFSET
      || aw_reg == SPECIAL_MODES_OFFSET || aw_reg == MANUAL_FC_OFFSET;

   // Address and data taken in either order or in the same cycle; one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_reg <= 8'h00;
         w_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_reg <= s_axi_wdata;
            ws_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Read-only strap registers refuse writes
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready = !w_have && !s_axi_bvalid;

   // ***************************************************
   // AXI4-Lite read channel
   // ***************************************************
   logic [31:0] rd_word;
   logic rd_ok;
   // Read mux; reserved bits zero
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         STRAP_CFG_OFFSET: rd_word[STRAP_W-1:0] = strap_reg;
         BASIC_CTRL_OFFSET: begin
            rd_word[SPEED_LSB_BIT] = speed_reg;
            rd_word[DUPLEX_BIT] = duplex_reg;
         end
         AN_ADV_OFFSET: begin
            rd_word[ADV_10FD_BIT] = adv_10fd_reg;
            rd_word[ADV_10HD_BIT] = adv_10hd_reg;
         end
         SPECIAL_MODES_OFFSET: rd_word[MODE_LSB +: MODE_W] = mode_reg;
         MANUAL_FC_OFFSET: begin
            rd_word[FC_BP_BIT] = bp_reg;
            rd_word[FC_RX_BIT] = rxfc_reg;
            rd_word[FC_TX_BIT] = txfc_reg;
            rd_word[FC_MANUAL_BIT] = manual_reg;
         end
         LOADER_OFFSET: begin
            rd_word[STRAP_W-1:0] = loader_straps;
            rd_word[LOADER_VALID_BIT] = loader_valid;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // One read outstanding; answer one cycle after arvalid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
   // ***************************************************
   // Assertions
   // ***************************************************
   sequence s_release;
      apply_now;
   endsequence
   property p_speed_default;
      s_release |=> speed_reg == $past(eff_straps[STRAP_SPEED_BIT]);
   endproperty
   a_speed_default: assert property (p_speed_default) else $error("speed default wrong");
   property p_duplex_default;
      s_release |=> duplex_reg == $past(eff_straps[STRAP_DUPLEX_BIT]);
   endproperty
   a_duplex_default: assert property (p_duplex_default) else $error("duplex wrong");
   property p_mode_default;
      s_release |=> mode_reg == {1'b0, $past(eff_straps[STRAP_SPEED_BIT]),
         $past(eff_straps[STRAP_DUPLEX_BIT])};
   endproperty
   a_mode_default: assert property (p_mode_default) else $error("mode default wrong");
   property p_bp_default;
      s_release |=> bp_reg == $past(eff_straps[STRAP_BP_BIT]);
   endproperty
   a_bp_default: assert property (p_bp_default) else $error("backpressure wrong");
   property p_pause_default;
      s_release |=> txfc_reg == $past(eff_straps[STRAP_PAUSE_BIT]) && rxfc_reg == txfc_reg;
   endproperty
   a_pause_default: assert property (p_pause_default) else $error("pause default wrong");
   property p_pause_out;
      port2_tx_pause_enable |-> $past(txfc_reg) && $past(manual_reg) && $past(duplex_reg);
   endproperty
   a_pause_out: assert property (p_pause_out) else $error("pause enable ungated");
endmodule : port2_strap_defaults

// *** design/strap_defaults_pkg.sv ***
package strap_defaults_pkg;
   // ***************************************************
   // Register byte offsets
   // ***************************************************
   localparam logic [7:0] STRAP_CFG_OFFSET = 8'h00;
   localparam logic [7:0] BASIC_CTRL_OFFSET = 8'h04;
   localparam logic [7:0] AN_ADV_OFFSET = 8'h08;
   localparam logic [7:0] SPECIAL_MODES_OFFSET = 8'h0C;
   localparam logic [7:0] MANUAL_FC_OFFSET = 8'h10;
   localparam logic [7:0] LOADER_OFFSET = 8'h14;

   // ***************************************************
   // Field positions
   // ***************************************************
   // Strap word: speed, duplex, backpressure, pause
   localparam int STRAP_SPEED_BIT = 0;
   localparam int STRAP_DUPLEX_BIT = 1;
   localparam int STRAP_BP_BIT = 2;
   localparam int STRAP_PAUSE_BIT = 3;
   localparam int STRAP_W = 4;
   // Basic control
   localparam int SPEED_LSB_BIT = 13;
   localparam int DUPLEX_BIT = 8;
   // Advertisement
   localparam int ADV_10FD_BIT = 6;
   localparam int ADV_10HD_BIT = 5;
   // Special modes
   localparam int MODE_LSB = 5;
   localparam int MODE_W = 3;
   // Manual flow control
   localparam int FC_BP_BIT = 0;
   localparam int FC_RX_BIT = 1;
   localparam int FC_TX_BIT = 2;
   localparam int FC_MANUAL_BIT = 3;
   // Loader register: valid flag above the strap nibble
   localparam int LOADER_VALID_BIT = 4;

   // ***************************************************
   // Reset values and field encodings
   // ***************************************************
   localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 4'hF;
   localparam logic [2:0] MODE_10HD = 3'h0;
   localparam logic [2:0] MODE_10FD = 3'h1;
   localparam logic [2:0] MODE_100HD = 3'h2;
   localparam logic [2:0] MODE_100FD = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : strap_defaults_pkg

// *** design/strap_sync.sv ***
`timescale 1ns/1ps
module strap_sync #(
   parameter int WIDTH = 4
) (
   input wire logic aclk,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // Two-stage synchroniser; first stage read only by second
   // No reset: pins must be sampled while the device is held in reset
   always_ff @(posedge aclk) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
   end
endmodule : strap_sync

// *** verification/strap_source.sv ***
`timescale 1ns/1ps
module strap_source (
   input wire logic aclk,
   input wire logic [strap_defaults_pkg::STRAP_W-1:0] pin_level,
   input wire logic use_loader,
   input wire logic [strap_defaults_pkg::STRAP_W-1:0] loader_level,
   output logic [strap_defaults_pkg::STRAP_W-1:0] strap_pins = '1,
   output logic loader_valid = 1'b0,
   output logic [strap_defaults_pkg::STRAP_W-1:0] loader_straps = '0
);
   import strap_defaults_pkg::*;
   // ***************************************************
   // Pins and EEPROM loader
   // ***************************************************
   // loader replaces pins
   // Unselected loader word shows junk, so a design that ignores valid is caught
   always @(posedge aclk) begin
      strap_pins <= pin_level;
      loader_valid <= use_loader;
      loader_straps <= use_loader ? loader_level : ~pin_level;
   end
endmodule : strap_source

// *** verification/tb_port2_strap_defaults.sv ***
`timescale 1ns/1ps
module tb_port2_strap_defaults;
   import strap_defaults_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [STRAP_W-1:0] pin_level = '1;
   logic use_loader = 1'b0;
   logic [STRAP_W-1:0] loader_level = '0;
   logic [STRAP_W-1:0] strap_pins;
   logic [STRAP_W-1:0] loader_straps;
   logic loader_valid;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   logic [1:0] r;
   logic speed_100, full_duplex, bp_en, tx_en, rx_en, manual;
   int mismatches = 0;
   int total_checks = 0;

   // Free-running system clock
   always #10 aclk = ~aclk;

   strap_source strap_source_inst (.aclk(aclk), .pin_level(pin_level), .use_loader(use_loader),
      .loader_level(loader_level), .strap_pins(strap_pins), .loader_valid(loader_valid),
      .loader_straps(loader_straps));

   port2_strap_defaults port2_strap_defaults_inst (.aclk(aclk), .aresetn(aresetn),
      .strap_pins(strap_pins), .loader_valid(loader_valid), .loader_straps(loader_straps),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .port2_speed_100(speed_100), .port2_full_duplex(full_duplex),
      .port2_backpressure_enable(bp_en), .port2_tx_pause_enable(tx_en),
      .port2_rx_pause_enable(rx_en), .port2_manual_flow_control(manual));

   // ***************************************************
   // Reporting
   // ***************************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task automatic check_word(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: response %h want %h", $time, got, exp);
      end
   endtask : check_resp

   // A wait that ran out ends the run at once
   task automatic bound(input int n);
      if (n >= 50) begin
         mismatches++;
         $display("unexpected at %0t: bus gave no answer", $time);
         tally_and_finish();
      end
   endtask : bound

   // ***************************************************
   // AXI4-Lite master
   // ***************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 50);
      bound(n);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 50);
      bound(n);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd

   // Reset with chosen pins and loader word; speed, duplex and backpressure outputs must sit low meanwhile
   task automatic restart(input logic [3:0] pins, input logic ld, input logic [3:0] lv);
      @(posedge aclk);
      aresetn <= 1'b0;
      pin_level <= pins;
      use_loader <= ld;
      loader_level <= lv;
      repeat (10) @(posedge aclk);
      check_word(8'({speed_100, full_duplex, bp_en}), 8'h0);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask : restart

   // Every strap-driven default against one strap nibble
   task automatic check_all(input logic [3:0] s);
      rd(BASIC_CTRL_OFFSET, d, r);
      check_resp(r, RESP_OKAY);
      check_word(8'({d[SPEED_LSB_BIT], d[DUPLEX_BIT]}), 8'({s[0], s[1]}));
      rd(AN_ADV_OFFSET, d, r);
      check_word(8'({d[ADV_10FD_BIT], d[ADV_10HD_BIT]}), 8'({s[0] | s[1], 1'b1}));
      rd(SPECIAL_MODES_OFFSET, d, r);
      check_word(8'(d[MODE_LSB +: MODE_W]), 8'({s[0], s[1]}));
      rd(MANUAL_FC_OFFSET, d, r);
      check_word(8'({d[FC_MANUAL_BIT], d[FC_TX_BIT], d[FC_RX_BIT], d[FC_BP_BIT]}),
         8'({1'b0, s[3], s[3], s[2]}));
      check_word(8'({speed_100, full_duplex, bp_en, manual, tx_en, rx_en}),
         8'({s[0], s[1], s[2], 3'b000}));
   endtask : check_all

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      for (int s = 0; s < 16; s++) begin
         restart(4'(s), 1'b0, 4'h0);
         check_all(4'(s));
      end
      restart(4'h0, 1'b1, 4'hA);
      check_all(4'hA);
      rd(STRAP_CFG_OFFSET, d, r);
      check_word(8'(d[3:0]), 8'hA);
      rd(LOADER_OFFSET, d, r);
      check_word(8'(d[4:0]), 8'h1A);
      restart(4'hF, 1'b0, 4'h0);
      wr(MANUAL_FC_OFFSET, 32'hF, r);
      check_resp(r, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_word(8'({tx_en, rx_en, manual}), 8'h7);
      // Half duplex must shut pause off though enables stay set
      wr(BASIC_CTRL_OFFSET, 32'h2000, r);
      repeat (2) @(posedge aclk);
      check_word(8'({speed_100, full_duplex, tx_en, rx_en}), 8'h8);
      restart(4'h7, 1'b0, 4'h0);
      wr(MANUAL_FC_OFFSET, 32'h9, r);
      repeat (2) @(posedge aclk);
      check_word(8'({bp_en, tx_en, rx_en, manual}), 8'h9);
      restart(4'h7, 1'b0, 4'h0);
      check_all(4'h7);
      // Unmapped and read-only places refuse writes
      wr(8'h18, 32'h0, r);
      check_resp(r, RESP_SLVERR);
      wr(STRAP_CFG_OFFSET, 32'h0, r);
      check_resp(r, RESP_SLVERR);
      tally_and_finish();
   end
endmodule : tb_port2_strap_defaults
